// ### hdl/tlp_formation_acs_checker.v
// TLP formation and ACS violation checker of a switch port bridge function.
// Assumes decoded TLP fields arrive as one-cycle valid pulses on core_clk.
//
// Operation
// - Interrupt, PM, error, unlock, power-limit messages must use class 0.
// - Route-to-root TLPs are illegal when received on an upstream port.
// - Broadcast TLPs are illegal when received on a downstream port.
// - Gathered routing is legal only downstream and only as PME turn-off ack.
// - Legacy interrupt messages are illegal on an upstream port.
// - Each received TLP class must map to channel 0 in ingress map.
// - Each sent TLP class must map to channel 0 or enabled channel 1.
// - Vendor type 1 message to bridge is silently discarded, nothing logged.
// - ACS checks apply only in downstream switch port mode.
// - ACS redirect is no error and logs nothing.
// - ACS block is a violation logged in error reporting.
// - No source validation on local or gathered routed messages.
// - Advisory only if severity nonfatal and TLP is non-posted.
// - Non-posted violation gets completer-abort completion, not logged as such.
// - ACS violation sets signaled target abort in secondary status.
// - Non-advisory uncorrectable, advisory correctable; header logged both ways.
// - Source validation, translation or egress failures are dropped.
// - Direct translated violation goes to egress control and redirect; here it blocks as egress control and is never redirected.
// - Ingress formation failure: uncorrectable, header logged, nullified.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "tlp_check_consts.vh"
module tlp_formation_acs_checker (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Ingress TLP decode
  input  wire        rx_valid,
  input  wire [2:0]  rx_tc,
  input  wire        rx_is_msg,
  input  wire [2:0]  rx_route,
  input  wire [2:0]  rx_msg_class,
  input  wire        rx_to_bridge,
  input  wire        rx_non_posted,
  input  wire [31:0] rx_header,
  // ACS check results from the routing fabric
  input  wire        acs_src_fail,
  input  wire        acs_xlat_fail,
  input  wire        acs_p2p_fail,
  input  wire        acs_direct_fail,
  input  wire        acs_redirect,
  // Ingress verdict
  output reg         rx_done,
  output reg         rx_nullify,
  output reg         rx_drop,
  output reg         rx_discard,
  output reg         rx_redirect,
  output reg         ca_cpl_req,
  // Egress TLP decode
  input  wire        tx_valid,
  input  wire [2:0]  tx_tc,
  input  wire [31:0] tx_header,
  // Egress verdict
  output reg         tx_done,
  output reg         tx_block,
  // Error processing pulses
  output reg         uncorr_err,
  output reg         corr_err
);

  // ==========================================================
  // Register state
  // Status bits without a set event stay at their reset value
  reg  [7:0]  ctrl_q;
  reg  [7:0]  ingress_map_q;
  reg  [7:0]  egress_map_q;
  reg  [7:0]  egress_vc1_q;
  reg  [7:0]  severity_q;
  reg  [15:0] sec_status_q;
  reg  [7:0]  uncorr_q;
  reg  [7:0]  corr_q;
  reg  [31:0] hdr_log_q;

  wire downstream = ctrl_q[`CTRL_DOWNSTREAM_BIT];
  wire vc1_en     = ctrl_q[`CTRL_VC1_EN_BIT];

  // ==========================================================
  // Class map lookups
  wire rx_mapped;
  wire tx_mapped;

  // Ingress checks channel 0 only
  tc_map_check u_rx_map (
    .tc      (rx_tc),
    .vc0_map (ingress_map_q),
    .vc1_map (8'h00),
    .vc1_en  (1'b0),
    .mapped  (rx_mapped)
  );

  // Egress may also land on an enabled channel 1
  tc_map_check u_tx_map (
    .tc      (tx_tc),
    .vc0_map (egress_map_q),
    .vc1_map (egress_vc1_q),
    .vc1_en  (vc1_en),
    .mapped  (tx_mapped)
  );

  // ==========================================================
  // Ingress formation checks
  // Message class, routing direction and class map; any hit is malformed
  wire tc0_class = rx_is_msg & ((rx_msg_class == `MSG_INTX) | (rx_msg_class == `MSG_PM) |
                   (rx_msg_class == `MSG_ERR) | (rx_msg_class == `MSG_UNLOCK) |
                   (rx_msg_class == `MSG_PWR_LIMIT));
  wire bad_tc0    = tc0_class & (rx_tc != `TC_ZERO);
  wire bad_root   = rx_is_msg & (rx_route == `RT_TO_ROOT) & ~downstream;
  wire bad_bcast  = rx_is_msg & (rx_route == `RT_BCAST) & downstream;
  wire bad_gather = rx_is_msg & (rx_route == `RT_GATHER) &
                    (~downstream | (rx_msg_class != `MSG_PME_TO_ACK));
  wire bad_intx   = rx_is_msg & (rx_msg_class == `MSG_INTX) & ~downstream;
  wire bad_map    = ~rx_mapped;
  wire malformed  = bad_tc0 | bad_root | bad_bcast | bad_gather | bad_intx | bad_map;

  // Vendor type 1 to the bridge is dropped without a trace
  wire vendor_discard = rx_is_msg & (rx_msg_class == `MSG_VENDOR1) & rx_to_bridge;

  // ==========================================================
  // ACS evaluation
  wire acs_exempt = rx_is_msg & ((rx_route == `RT_LOCAL) | (rx_route == `RT_GATHER));
  wire src_fail   = acs_src_fail & ~acs_exempt;
  wire p2p_fail   = acs_p2p_fail | acs_direct_fail;
  wire acs_active = downstream & ~malformed & ~vendor_discard;
  // Blocking checks count only where ACS applies
  wire viol_src   = acs_active & src_fail;
  wire viol_xlat  = acs_active & acs_xlat_fail;
  wire viol_p2p   = acs_active & p2p_fail;
  wire acs_viol   = viol_src | viol_xlat | viol_p2p;
  // A fatal severity bit makes the violation non-advisory
  wire viol_fatal = (viol_src  & severity_q[`SEV_SRC_VALID_BIT]) |
                    (viol_xlat & severity_q[`SEV_XLAT_BLOCK_BIT]) |
                    (viol_p2p  & severity_q[`SEV_P2P_EGRESS_BIT]);
  wire advisory   = acs_viol & ~viol_fatal & rx_non_posted;
  // Redirect only when no block wins
  wire redirect   = acs_active & ~acs_viol & (acs_redirect | acs_direct_fail);

  // ==========================================================
  // Egress check
  // Class must land on channel 0, or on channel 1 when enabled
  wire tx_bad = ~tx_mapped;

  // ==========================================================
  // Ingress verdict pulses, one cycle after rx_valid
  // Malformed wins over ACS, so nullify and drop never come together
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_done     <= 1'b0;
      rx_nullify  <= 1'b0;
      rx_drop     <= 1'b0;
      rx_discard  <= 1'b0;
      rx_redirect <= 1'b0;
      ca_cpl_req  <= 1'b0;
    end else begin
      rx_done     <= rx_valid;
      rx_nullify  <= rx_valid & malformed;
      rx_drop     <= rx_valid & acs_viol;
      rx_discard  <= rx_valid & vendor_discard & ~malformed;
      rx_redirect <= rx_valid & redirect;
      ca_cpl_req  <= rx_valid & acs_viol & rx_non_posted;
    end
  end

  // ==========================================================
  // Egress verdict pulses, one cycle after tx_valid
  // A blocked TLP is held back from the link
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_done     <= 1'b0;
      tx_block    <= 1'b0;
    end else begin
      tx_done     <= tx_valid;
      tx_block    <= tx_valid & tx_bad;
    end
  end

  // ==========================================================
  // Error processing requests from both paths
  // Advisory violations take the correctable way, all others uncorrectable
  wire rx_uncorr = rx_valid & (malformed | (acs_viol & ~advisory));
  wire tx_uncorr = tx_valid & tx_bad;
  wire rx_corr   = rx_valid & advisory;

  // Both paths may report in one cycle; the pulses merge
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uncorr_err  <= 1'b0;
      corr_err    <= 1'b0;
    end else begin
      uncorr_err  <= rx_uncorr | tx_uncorr;
      corr_err    <= rx_corr;
    end
  end

  // ==========================================================
  // Register write decode
  // Unmapped offsets decode to nothing, so writes there are lost
  wire wr_ctrl  = reg_wr & (reg_addr == `REG_CTRL);
  wire wr_imap  = reg_wr & (reg_addr == `REG_INGRESS_MAP);
  wire wr_emap  = reg_wr & (reg_addr == `REG_EGRESS_MAP);
  wire wr_sev   = reg_wr & (reg_addr == `REG_SEVERITY);
  wire wr_sec   = reg_wr & (reg_addr == `REG_SEC_STATUS);
  wire wr_unc   = reg_wr & (reg_addr == `REG_UNCORR_STATUS);
  wire wr_cor   = reg_wr & (reg_addr == `REG_CORR_STATUS);

  // ==========================================================
  // Hardware set events of the status registers
  // Each event is qualified by its valid strobe
  wire set_sta  = rx_valid & acs_viol;
  wire set_mal  = rx_valid & malformed;
  wire set_acs  = rx_valid & acs_viol & ~advisory;
  wire set_adv  = rx_valid & advisory;
  wire set_emal = tx_valid & tx_bad;
  wire log_hdr  = set_mal | (rx_valid & acs_viol) | set_emal;

  // ==========================================================
  // Configuration registers, written from the register port
  // Bits above each field's width are ignored
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q        <= `CTRL_RESET;
      ingress_map_q <= `INGRESS_MAP_RESET;
      egress_map_q  <= `EGRESS_MAP_RESET;
      egress_vc1_q  <= `EGRESS_VC1_RESET;
      severity_q    <= `SEVERITY_RESET;
    end else begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata[7:0];
      if (wr_imap)
        ingress_map_q <= reg_wdata[7:0];
      if (wr_emap) begin
        egress_map_q <= reg_wdata[7:0];
        egress_vc1_q <= reg_wdata[15:8];
      end
      if (wr_sev)
        severity_q <= reg_wdata[7:0];
    end
  end

  // ==========================================================
  // Secondary status: signaled target abort flag, write one to clear
  // Hardware set wins, so a violation in the clearing cycle is kept
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_status_q <= `SEC_STATUS_RESET;
    end else begin
      sec_status_q[`SEC_TARGET_ABORT_BIT] <= set_sta |
        (sec_status_q[`SEC_TARGET_ABORT_BIT] & ~(wr_sec & reg_wdata[`SEC_TARGET_ABORT_BIT]));
    end
  end

  // ==========================================================
  // Uncorrectable status, one write-one-to-clear cell per bit
  reg  [7:0] unc_set;
  wire [7:0] uncorr_d;
  genvar     gi;

  // Set vector; bits without an event never set and read zero
  always @* begin
    unc_set                      = 8'h00;
    unc_set[`UNC_MALFORMED_BIT]  = set_mal;
    unc_set[`UNC_ACS_BIT]        = set_acs;
    unc_set[`UNC_EGRESS_MAL_BIT] = set_emal;
  end

  // Next value per bit, hardware set wins over clear
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_unc_bit
      assign uncorr_d[gi] = unc_set[gi] | (uncorr_q[gi] & ~(wr_unc & reg_wdata[gi]));
    end
  endgenerate

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uncorr_q <= `UNC_STATUS_RESET;
    end else begin
      uncorr_q <= uncorr_d;
    end
  end

  // ==========================================================
  // Correctable status: advisory ACS bit, write one to clear
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      corr_q <= `COR_STATUS_RESET;
    end else begin
      corr_q[`COR_ADVISORY_BIT] <= set_adv |
        (corr_q[`COR_ADVISORY_BIT] & ~(wr_cor & reg_wdata[`COR_ADVISORY_BIT]));
    end
  end

  // ==========================================================
  // Header log keeps the last failing header
  // Ingress wins over egress when both fail in one cycle
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_log_q <= `HDR_LOG_RESET;
    end else if (log_hdr) begin
      hdr_log_q <= (set_mal | (rx_valid & acs_viol)) ? rx_header : tx_header;
    end
  end

  // ==========================================================
  // Read multiplexer; unmapped words and idle cycles give zero
  reg  [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:          rdata_d = {24'h000000, ctrl_q};
        `REG_INGRESS_MAP:   rdata_d = {24'h000000, ingress_map_q};
        `REG_EGRESS_MAP:    rdata_d = {16'h0000, egress_vc1_q, egress_map_q};
        `REG_SEVERITY:      rdata_d = {24'h000000, severity_q};
        `REG_SEC_STATUS:    rdata_d = {16'h0000, sec_status_q};
        `REG_UNCORR_STATUS: rdata_d = {24'h000000, uncorr_q};
        `REG_CORR_STATUS:   rdata_d = {24'h000000, corr_q};
        `REG_HDR_LOG:       rdata_d = hdr_log_q;
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RDATA_RESET;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// ### hdl/tlp_check_consts.vh
// Constants for the TLP formation and ACS checker: register offsets,
// field positions, reset values and TLP encodings.
// Assumes inclusion by bare name from the checker design files.
`ifndef TLP_CHECK_CONSTS_VH
`define TLP_CHECK_CONSTS_VH

// ==========================================================
// Register offsets (word index on the plain register port)
`define REG_CTRL          4'h0
`define REG_INGRESS_MAP   4'h1
`define REG_EGRESS_MAP    4'h2
`define REG_SEVERITY      4'h3
`define REG_SEC_STATUS    4'h4
`define REG_UNCORR_STATUS 4'h5
`define REG_CORR_STATUS   4'h6
`define REG_HDR_LOG       4'h7

// ==========================================================
// Control register fields
`define CTRL_DOWNSTREAM_BIT 0
`define CTRL_VC1_EN_BIT     1
`define CTRL_RESET          8'h00

// Class-to-channel map resets: all classes to channel 0 ingress and egress, none to egress channel 1
`define INGRESS_MAP_RESET   8'hFF
`define EGRESS_MAP_RESET    8'hFF
`define EGRESS_VC1_RESET    8'h00
`define SEVERITY_RESET      8'h00
`define SEC_STATUS_RESET    16'h0000
`define UNC_STATUS_RESET    8'h00
`define COR_STATUS_RESET    8'h00
`define HDR_LOG_RESET       32'h0000_0000
`define RDATA_RESET         32'h0000_0000

// Severity bits (1 = fatal)
`define SEV_SRC_VALID_BIT   0
`define SEV_XLAT_BLOCK_BIT  1
`define SEV_P2P_EGRESS_BIT  2

// Secondary status bit positions
`define SEC_TARGET_ABORT_BIT 11

// Uncorrectable status bits
`define UNC_MALFORMED_BIT    0
`define UNC_ACS_BIT          1
`define UNC_EGRESS_MAL_BIT   2
// Correctable status bits
`define COR_ADVISORY_BIT     0

// ==========================================================
// TLP routing codes (type[2:0] of message)
`define RT_TO_ROOT      3'h0
`define RT_BCAST        3'h3
`define RT_LOCAL        3'h4
`define RT_GATHER       3'h5

// Message classes carried on the ingress class port
`define MSG_NONE        3'h0
`define MSG_INTX        3'h1
`define MSG_PM          3'h2
`define MSG_ERR         3'h3
`define MSG_UNLOCK      3'h4
`define MSG_PWR_LIMIT   3'h5
`define MSG_PME_TO_ACK  3'h6
`define MSG_VENDOR1     3'h7

`define TC_ZERO         3'h0

`endif

// ### hdl/tc_map_check.v
// Traffic class to virtual channel map lookup.
// Assumes map vectors are stable registers on the same clock.
`timescale 1ns/1ps
module tc_map_check (
  // Class under test
  input  wire [2:0] tc,
  // Maps: bit n set means class n maps to that channel
  input  wire [7:0] vc0_map,
  input  wire [7:0] vc1_map,
  input  wire       vc1_en,
  // Result
  output wire       mapped
);

  // Class legal if it lands on channel 0 or an enabled channel 1
  assign mapped = vc0_map[tc] | (vc1_en & vc1_map[tc]);

endmodule

// ### tb/tlp_checker_sva.sv
// Port assertions for the TLP formation and ACS checker.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "tlp_check_consts.vh"
module tlp_checker_sva (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_b,
  // Ingress and egress requests
  input wire        rx_valid,
  input wire [2:0]  rx_tc,
  input wire        rx_is_msg,
  input wire [2:0]  rx_msg_class,
  input wire        rx_non_posted,
  input wire        tx_valid,
  // Verdicts
  input wire        rx_done,
  input wire        rx_nullify,
  input wire        rx_drop,
  input wire        rx_discard,
  input wire        rx_redirect,
  input wire        ca_cpl_req,
  input wire        tx_done,
  input wire        tx_block,
  input wire        uncorr_err,
  input wire        corr_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ======
  // Sequences
  sequence s_bad_class;
    rx_valid && rx_is_msg && rx_msg_class >= `MSG_INTX && rx_msg_class <= `MSG_PWR_LIMIT && rx_tc != `TC_ZERO;
  endsequence
  sequence s_malformed;
    rx_done && rx_nullify && uncorr_err;
  endsequence
  // ======
  // Properties
  AST_TC0_MSG: assert property (s_bad_class |=> s_malformed)
    else $error("nonzero class message not nullified");
  AST_RX_DONE: assert property (rx_valid |=> rx_done)
    else $error("received TLP without verdict");
  AST_TX_DONE: assert property (tx_valid |=> tx_done)
    else $error("sent TLP without verdict");
  AST_TX_BLOCK: assert property (tx_block |-> tx_done && uncorr_err)
    else $error("egress block without error");
  AST_NULLIFY: assert property (rx_nullify |-> uncorr_err && !rx_drop && !ca_cpl_req)
    else $error("malformed TLP handled wrongly");
  AST_CA_CPL: assert property (ca_cpl_req |-> rx_drop && $past(rx_non_posted))
    else $error("abort completion without dropped request");
  AST_ADVISORY: assert property (corr_err |-> rx_drop && $past(rx_non_posted))
    else $error("advisory error on posted TLP");
  AST_DISCARD: assert property (rx_discard |-> !rx_drop && !rx_nullify && !corr_err && !ca_cpl_req)
    else $error("discarded message was reported");
  AST_REDIRECT: assert property (rx_redirect |-> !rx_drop && !rx_nullify && !corr_err && !ca_cpl_req)
    else $error("redirect reported as error");
endmodule
bind tlp_formation_acs_checker tlp_checker_sva u_sva (.core_clk, .rst_b, .rx_valid, .rx_tc, .rx_is_msg,
  .rx_msg_class, .rx_non_posted, .tx_valid, .rx_done, .rx_nullify, .rx_drop, .rx_discard, .rx_redirect,
  .ca_cpl_req, .tx_done, .tx_block, .uncorr_err, .corr_err);

// ### tb/acs_fabric_model.sv
// Routing fabric model: ACS check results for a received TLP.
// Assumes the bench sets mode just after a clock edge, level with rx_valid.
`timescale 1ns/1ps
module acs_fabric_model (
  // Outcome: 1 source, 2 translation, 3 egress, 4 redirect, else pass
  input  wire [2:0] mode,
  input  wire       direct,
  // Check results
  output wire       acs_src_fail,
  output wire       acs_xlat_fail,
  output wire       acs_p2p_fail,
  output wire       acs_direct_fail,
  output wire       acs_redirect
);
  // Decode requested outcome
  assign acs_src_fail    = (mode == 3'h1);
  assign acs_xlat_fail   = (mode == 3'h2);
  assign acs_p2p_fail    = (mode == 3'h3);
  assign acs_direct_fail = (mode == 3'h3) && direct;
  assign acs_redirect    = (mode == 3'h4);
endmodule

// ### tb/testbench.sv
// Self-checking bench for the TLP formation and ACS checker.
// Assumes design, checker and fabric model are compiled first.
`timescale 1ns/1ps
`include "tlp_check_consts.vh"
module testbench;
  // ======
  // Signals and model state
  reg         core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [31:0] reg_wdata = 32'h0, rx_header = 32'h0, tx_header = 32'h0, hdr_m = 32'h0, seed = 32'h18;
  wire [31:0] reg_rdata;
  reg         rx_valid = 1'b0, rx_is_msg = 1'b0, rx_to_bridge = 1'b0, rx_non_posted = 1'b0;
  reg         tx_valid = 1'b0, direct = 1'b0, sec_m = 1'b0, cor_m = 1'b0;
  reg  [2:0]  rx_tc = 3'h0, rx_route = 3'h0, rx_msg_class = 3'h0, tx_tc = 3'h0, mode = 3'h0;
  reg  [2:0]  sev_m = 3'h0, unc_m = 3'h0;
  reg  [1:0]  ctrl_m = 2'h0;
  reg  [7:0]  imap_m = 8'hFF;
  reg  [15:0] emap_m = 16'h00FF;
  wire        src_f, xlat_f, p2p_f, dir_f, redir, tx_done, tx_block, uncorr_err, corr_err;
  wire        rx_done, rx_nullify, rx_drop, rx_discard, rx_redirect, ca_cpl_req;
  integer     errors = 0, compares = 0, i;
  // Instances
  acs_fabric_model u_acs_fabric_model (.mode(mode), .direct(direct), .acs_src_fail(src_f),
    .acs_xlat_fail(xlat_f), .acs_p2p_fail(p2p_f), .acs_direct_fail(dir_f), .acs_redirect(redir));
  tlp_formation_acs_checker u_tlp_formation_acs_checker (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_tc(rx_tc), .rx_is_msg(rx_is_msg), .rx_route(rx_route),
    .rx_msg_class(rx_msg_class), .rx_to_bridge(rx_to_bridge), .rx_non_posted(rx_non_posted),
    .rx_header(rx_header), .acs_src_fail(src_f), .acs_xlat_fail(xlat_f), .acs_p2p_fail(p2p_f),
    .acs_direct_fail(dir_f), .acs_redirect(redir), .rx_done(rx_done), .rx_nullify(rx_nullify),
    .rx_drop(rx_drop), .rx_discard(rx_discard), .rx_redirect(rx_redirect), .ca_cpl_req(ca_cpl_req),
    .tx_valid(tx_valid), .tx_tc(tx_tc), .tx_header(tx_header), .tx_done(tx_done), .tx_block(tx_block),
    .uncorr_err(uncorr_err), .corr_err(corr_err));
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  // ======
  // Helpers
  function [31:0] rnd;
    input integer u;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task summarize;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Register write, model follows
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      case (a)
        `REG_CTRL: ctrl_m = d[1:0];
        `REG_INGRESS_MAP: imap_m = d[7:0];
        `REG_EGRESS_MAP: emap_m = d[15:0];
        `REG_SEVERITY: sev_m = d[2:0];
        `REG_SEC_STATUS: sec_m = sec_m & ~d[11];
        `REG_UNCORR_STATUS: unc_m = unc_m & ~d[2:0];
        `REG_CORR_STATUS: cor_m = cor_m & ~d[0];
        default: ;
      endcase
    end
  endtask
  // Register read, compared in the answer cycle
  task rd_chk(input [3:0] a, input [31:0] e);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk("reg_rdata", e, reg_rdata);
    end
  endtask
  // Random received TLP against the model
  task send_rx;
    reg [31:0] r;
    reg [2:0]  rt;
    reg        ds, mal, disc, sv, viol, fat, adv;
    begin
      r = rnd(0);
      rt = {r[8], ~r[8] & r[7], r[7]};
      ds = ctrl_m[0];
      mal = !imap_m[r[2:0]] || (r[3] && ((r[6:4] >= `MSG_INTX && r[6:4] <= `MSG_PWR_LIMIT && r[2:0] != 3'h0)
        || (rt == `RT_TO_ROOT && !ds) || (rt == `RT_BCAST && ds) || (r[6:4] == `MSG_INTX && !ds)
        || (rt == `RT_GATHER && (!ds || r[6:4] != `MSG_PME_TO_ACK))));
      disc = !mal && r[3] && r[9] && r[6:4] == `MSG_VENDOR1;
      sv = ds && !mal && !disc;
      viol = sv && (r[13:11] == 3'h2 || r[13:11] == 3'h3
        || (r[13:11] == 3'h1 && !(r[3] && (rt == `RT_LOCAL || rt == `RT_GATHER))));
      fat = (r[13:11] == 3'h1) ? sev_m[0] : (r[13:11] == 3'h2) ? sev_m[1] : sev_m[2];
      adv = viol && r[10] && !fat;
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_tc <= r[2:0];
      rx_is_msg <= r[3];
      rx_msg_class <= r[6:4];
      rx_route <= rt;
      rx_to_bridge <= r[9];
      rx_non_posted <= r[10];
      mode <= r[13:11];
      direct <= r[14];
      rx_header <= ~r;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      @(negedge core_clk);
      chk("rx verdict", {24'h0, 1'b1, mal, viol, disc, sv && r[13:11] == 3'h4, viol && r[10], mal || (viol && !adv),
        adv}, {24'h0, rx_done, rx_nullify, rx_drop, rx_discard, rx_redirect, ca_cpl_req, uncorr_err, corr_err});
      if (mal || viol)
        hdr_m = ~r;
      sec_m = sec_m | viol;
      unc_m = unc_m | {1'b0, viol && !adv, mal};
      cor_m = cor_m | adv;
    end
  endtask
  // Random sent TLP against the model
  task send_tx;
    reg [31:0] r;
    reg        blk;
    begin
      r = rnd(0);
      blk = !(emap_m[r[2:0]] || (ctrl_m[1] && emap_m[r[2:0] + 8]));
      @(posedge core_clk);
      tx_valid <= 1'b1;
      tx_tc <= r[2:0];
      tx_header <= r;
      @(posedge core_clk);
      tx_valid <= 1'b0;
      @(negedge core_clk);
      chk("tx verdict", {29'h0, 1'b1, blk, blk}, {29'h0, tx_done, tx_block, uncorr_err});
      if (blk)
        hdr_m = r;
      unc_m[2] = unc_m[2] | blk;
    end
  endtask
  // ======
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i = i + 1)
      rd_chk(i[3:0], (i == 1 || i == 2) ? 32'hFF : 32'h0);
    wr(4'hC, 32'hFFFFFFFF);
    rd_chk(4'hC, 32'h0);
    for (i = 0; i < 480; i = i + 1) begin
      if (i % 16 == 0) begin
        wr(`REG_CTRL, rnd(0) & 32'h3);
        wr(`REG_INGRESS_MAP, rnd(0) & 32'hFF);
        wr(`REG_EGRESS_MAP, rnd(0) & 32'hFFFF);
        wr(`REG_SEVERITY, rnd(0) & 32'h7);
        rd_chk(`REG_SEVERITY, {29'h0, sev_m});
      end
      send_rx;
      if (i % 2 == 1)
        send_tx;
      if (i % 60 == 59) begin
        rd_chk(`REG_SEC_STATUS, {20'h0, sec_m, 11'h0});
        rd_chk(`REG_UNCORR_STATUS, {29'h0, unc_m});
        rd_chk(`REG_CORR_STATUS, {31'h0, cor_m});
        rd_chk(`REG_HDR_LOG, hdr_m);
        wr(`REG_SEC_STATUS, 32'h800);
        wr(`REG_UNCORR_STATUS, 32'h7);
        wr(`REG_CORR_STATUS, 32'h1);
        rd_chk(`REG_UNCORR_STATUS, 32'h0);
      end
    end
    summarize;
  end
  // Watchdog
  initial begin
    #4000000;
    errors = errors + 1;
    summarize;
  end
endmodule
